/* File: pkg/pfs_pkg.sv */
// Constants and types for the pin function and interrupt pin select block.
// Assumes a 32-bit APB register bus with byte addresses.
package pfs_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NPIN   = 8;
  localparam int PSEL_W = 5;
  localparam int NFUNC  = 32;
  localparam int AW     = 12;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [AW-1:0] PFS_BASE   = 12'h000; // one word per pin
  localparam logic [AW-1:0] WPROT_OFF  = 12'h020;
  localparam logic [AW-1:0] PMODE_OFF  = 12'h024;
  localparam logic [AW-1:0] PDIR_OFF   = 12'h028;
  localparam logic [AW-1:0] POUT_OFF   = 12'h02c;
  localparam logic [AW-1:0] PIN_OFF    = 12'h030;
  localparam logic [AW-1:0] IRQCR_BASE = 12'h040; // one word per pin
  localparam logic [AW-1:0] FLTE_OFF   = 12'h060;
  localparam logic [AW-1:0] FLTC_OFF   = 12'h064;
  localparam logic [AW-1:0] IRQST_OFF  = 12'h068;
  localparam logic [AW-1:0] REG_STRIDE = 12'h004;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PFS_PSEL_LSB = 0;
  localparam int PFS_IRQ_INPUT_SELECT_BIT = 6;
  localparam int PFS_ANALOG_INPUT_SELECT_BIT = 7;
  localparam int WP_FWE_BIT   = 6;
  localparam int WP_LOCK_BIT  = 7;
  localparam int IRQ_DETECT_MODE_LSB    = 2;
  localparam int IRQ_DETECT_MODE_W      = 2;
  localparam int FLTC_W       = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PSEL_W-1:0] PSEL_RST = 5'h00;
  localparam logic [NPIN-1:0]   BITS_RST = 8'h00;
  localparam logic              LOCK_RST = 1'b1;
  localparam logic              FILT_RST = 1'b1;

  // ****************************************************************
  // Filter prescaler
  // ****************************************************************
  localparam int               PRE_W    = 6;
  localparam logic [PRE_W-1:0] PRE_DIV8  = 6'h07;
  localparam logic [PRE_W-1:0] PRE_DIV32 = 6'h1f;
  localparam logic [PRE_W-1:0] PRE_DIV64 = 6'h3f;
  localparam logic [PRE_W-1:0] PRE_STEP  = 6'h01;

  typedef enum logic [FLTC_W-1:0] {
    PFS_RATE_DIV1  = 2'h0,
    PFS_RATE_DIV8  = 2'h1,
    PFS_RATE_DIV32 = 2'h2,
    PFS_RATE_DIV64 = 2'h3
  } pfs_rate_t;

  typedef enum logic [IRQ_DETECT_MODE_W-1:0] {
    PFS_DET_LOW  = 2'h0,
    PFS_DET_FALL = 2'h1,
    PFS_DET_RISE = 2'h2,
    PFS_DET_BOTH = 2'h3
  } pfs_det_t;

endpackage : pfs_pkg

/* File: pkg/pfs_filt_if.sv */
// Carrier between the register block and one pin's noise filter.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface pfs_filt_if;
  logic raw;
  logic enable;
  logic tick;
  logic level;

  modport ctrl (output raw, output enable, output tick, input level);
  modport filt (input raw, input enable, input tick, output level);
endinterface : pfs_filt_if

/* File: rtl/pfs_filter.sv */
// Interrupt pin digital noise filter for one pin.
// Assumes raw is already synchronised to pclk and tick is a pclk pulse.
`timescale 1ns/1ps
module pfs_filter
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to register block
  pfs_filt_if.filt fi
);

  logic [1:0] hist_r;
  logic       filt_r;
  logic       smp;

  assign smp = fi.raw;

  // ****************************************************************
  // Sample history and vote
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r <= {FILT_RST, FILT_RST};
    end else if (fi.tick) begin // R10
      hist_r <= {hist_r[0], smp};
    end
  end

  // Three agreeing samples needed, so shorter pulses never pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= FILT_RST;
    end else if (fi.tick && (hist_r[1] == smp) && (hist_r[0] == smp)) begin
      filt_r <= smp; // R11 R22
    end
  end

  // Bypass keeps the unfiltered path free of filter latency
  assign fi.level = fi.enable ? filt_r : fi.raw; // R12 R13

endmodule : pfs_filter

/* File: rtl/pfs_top.sv */
// Pin function multiplexer with interrupt pin detection and noise filters.
// Assumes an APB master on pclk; pins and peripheral lines on pclk or async pins.
`timescale 1ns/1ps

// Function
// [R1] One function select register per pin
// [R2] Analog pins left as general inputs
// [R3] Clear port mode before changing function
// [R4] Function registers locked after reset
// [R5] Unlock: clear lock bit, then set enable
// [R6] One function on many pins allowed
// [R7] Interrupt input only while select bit set
// [R8] Peripheral and interrupt may share pin
// [R9] Detect mode: low, fall, rise, both
// [R10] Filter rates: clock over 1,8,32,64
// [R11] Pulses under three samples suppressed
// [R12] Filter adds latency when enabled
// [R13] Filter enable per pin
// [R14] Filter rate per pin
// [R15] Deep standby pins can wake device
// [R16] Value 0x40 selects interrupt only
// [R17] Select code picks routed peripheral signal
// [R18] Configure, unlock, write, then set mode
// [R19] Missing pins set output driving zero
// [R20] Port mode one hands pin to peripheral
// [R21] Reset leaves every pin general input
// [R22] Level changes after three agreeing samples
// [R23] Enable settable only while lock clear
module pfs_top
  import pfs_pkg::*;
#(
  parameter logic [NPIN-1:0] DS_WAKE_MASK = 8'h0f
)(
  // APB slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [AW-1:0]    paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Port pins
  input  wire logic [NPIN-1:0]  pin_in,
  output logic      [NPIN-1:0]  pin_out,
  output logic      [NPIN-1:0]  pin_oe_n,
  output logic      [NPIN-1:0]  analog_en,
  // Peripheral side
  input  wire logic [NFUNC-1:0] func_out,
  input  wire logic [NFUNC-1:0] func_oe,
  output logic      [NFUNC-1:0] func_in,
  // Interrupt controller and standby
  output logic      [NPIN-1:0]  irq_req,
  input  wire logic             deep_standby,
  output logic                  ds_wake
);

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  function automatic logic in_bank(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d = a - base;
    in_bank = (a >= base) && (d < AW'(NPIN * 4)) && (a[1:0] == 2'h0);
  endfunction : in_bank

  function automatic logic [2:0] bank_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d = a - base;
    bank_idx = d[4:2];
  endfunction : bank_idx

  function automatic logic is_known(input logic [AW-1:0] a);
    is_known = in_bank(a, PFS_BASE) || in_bank(a, IRQCR_BASE) ||
               (a == WPROT_OFF) || (a == PMODE_OFF) || (a == PDIR_OFF) ||
               (a == POUT_OFF) || (a == PIN_OFF) || (a == FLTE_OFF) ||
               (a == FLTC_OFF) || (a == IRQST_OFF);
  endfunction : is_known

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [PSEL_W-1:0]      psel_r   [NPIN];
  logic [NPIN-1:0]        irq_input_select_r;
  logic [NPIN-1:0]        analog_input_select_r;
  logic                   lock_r;
  logic                   fwe_r;
  logic [NPIN-1:0]        pmode_r;
  logic [NPIN-1:0]        pdir_r;
  logic [NPIN-1:0]        pout_r;
  pfs_det_t               detmd_r  [NPIN];
  logic [NPIN-1:0]        flte_r;
  logic [NPIN*FLTC_W-1:0] fltc_r;
  logic [PRE_W-1:0]       pre_r;
  logic [NPIN-1:0]        sync1_r;
  logic [NPIN-1:0]        sync2_r;
  logic [NPIN-1:0]        lvl_prev_r;
  logic [NPIN-1:0]        irq_r;
  logic [31:0]            prdata_r;
  logic [31:0]            rd_nxt;
  logic [NPIN-1:0]        filt_lvl;
  logic                   wr_acc;
  logic                   rd_acc;
  logic [2:0]             widx;
  logic [2:0]             ridx;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign widx   = in_bank(paddr, PFS_BASE) ? bank_idx(paddr, PFS_BASE)
                                           : bank_idx(paddr, IRQCR_BASE);
  assign ridx   = widx;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_known(paddr);
  assign prdata  = prdata_r;

  // ****************************************************************
  // Write protection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= LOCK_RST; // R4
      fwe_r  <= 1'b0;
    end else if (wr_acc && (paddr == WPROT_OFF)) begin
      lock_r <= pwdata[WP_LOCK_BIT];
      // Old lock value is used, so one write cannot clear and enable at once
      fwe_r  <= pwdata[WP_FWE_BIT] && !lock_r; // R5 R23
    end
  end

  // ****************************************************************
  // Function select registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPIN; i++) begin
        psel_r[i] <= PSEL_RST; // R21
      end
      irq_input_select_r <= BITS_RST;
      analog_input_select_r <= BITS_RST;
    end else if (wr_acc && in_bank(paddr, PFS_BASE) && fwe_r) begin // R4
      psel_r[widx] <= pwdata[PFS_PSEL_LSB +: PSEL_W]; // R1 R17
      irq_input_select_r[widx] <= pwdata[PFS_IRQ_INPUT_SELECT_BIT];           // R16
      analog_input_select_r[widx] <= pwdata[PFS_ANALOG_INPUT_SELECT_BIT];
    end
  end

  // ****************************************************************
  // Port mode, direction and output latch
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode_r <= BITS_RST; // R21
      pdir_r  <= BITS_RST;
      pout_r  <= BITS_RST;
    end else if (wr_acc) begin
      if (paddr == PMODE_OFF) begin
        pmode_r <= pwdata[NPIN-1:0];
      end
      if (paddr == PDIR_OFF) begin
        pdir_r <= pwdata[NPIN-1:0];
      end
      if (paddr == POUT_OFF) begin
        pout_r <= pwdata[NPIN-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt control and filter settings
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPIN; i++) begin
        detmd_r[i] <= PFS_DET_LOW;
      end
      flte_r <= BITS_RST;
      fltc_r <= '0;
    end else if (wr_acc) begin
      if (in_bank(paddr, IRQCR_BASE)) begin
        detmd_r[widx] <= pfs_det_t'(pwdata[IRQ_DETECT_MODE_LSB +: IRQ_DETECT_MODE_W]); // R9
      end
      if (paddr == FLTE_OFF) begin
        flte_r <= pwdata[NPIN-1:0]; // R13
      end
      if (paddr == FLTC_OFF) begin
        fltc_r <= pwdata[NPIN*FLTC_W-1:0]; // R14
      end
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (in_bank(paddr, PFS_BASE)) begin
      rd_nxt[PFS_PSEL_LSB +: PSEL_W] = psel_r[ridx];
      rd_nxt[PFS_IRQ_INPUT_SELECT_BIT]           = irq_input_select_r[ridx];
      rd_nxt[PFS_ANALOG_INPUT_SELECT_BIT]           = analog_input_select_r[ridx];
    end else if (in_bank(paddr, IRQCR_BASE)) begin
      rd_nxt[IRQ_DETECT_MODE_LSB +: IRQ_DETECT_MODE_W] = detmd_r[ridx];
    end else begin
      case (paddr)
        WPROT_OFF: begin
          rd_nxt[WP_LOCK_BIT] = lock_r;
          rd_nxt[WP_FWE_BIT]  = fwe_r;
        end
        PMODE_OFF: rd_nxt[NPIN-1:0] = pmode_r;
        PDIR_OFF:  rd_nxt[NPIN-1:0] = pdir_r;
        POUT_OFF:  rd_nxt[NPIN-1:0] = pout_r;
        PIN_OFF:   rd_nxt[NPIN-1:0] = sync2_r;
        FLTE_OFF:  rd_nxt[NPIN-1:0] = flte_r;
        FLTC_OFF:  rd_nxt[NPIN*FLTC_W-1:0] = fltc_r;
        IRQST_OFF: rd_nxt[NPIN-1:0] = filt_lvl;
        default:   rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data is registered in the setup cycle, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= BITS_RST;
      sync2_r <= BITS_RST;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************************************
  // Pin output multiplexer
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (analog_input_select_r[i]) begin
        // Output buffer forced off so analog pins never fight the source
        pin_out[i]  = 1'b0;
        pin_oe_n[i] = 1'b1;
      end else if (pmode_r[i]) begin
        pin_out[i]  = func_out[psel_r[i]]; // R20 R17
        pin_oe_n[i] = !func_oe[psel_r[i]];
      end else begin
        pin_out[i]  = pout_r[i];
        pin_oe_n[i] = !pdir_r[i];
      end
    end
  end

  assign analog_en = analog_input_select_r;

  // Several pins on one function are OR-ed; the result is not meaningful
  always_comb begin
    func_in = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (pmode_r[i] && !analog_input_select_r[i]) begin
        func_in[psel_r[i]] = func_in[psel_r[i]] | sync2_r[i]; // R6 R8
      end
    end
  end

  // ****************************************************************
  // Filter clock prescaler
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PRE_STEP;
    end
  end

  function automatic logic rate_tick(input pfs_rate_t r, input logic [PRE_W-1:0] c);
    case (r)
      PFS_RATE_DIV1:  rate_tick = 1'b1;
      PFS_RATE_DIV8:  rate_tick = (c[2:0] == PRE_DIV8[2:0]);
      PFS_RATE_DIV32: rate_tick = (c[4:0] == PRE_DIV32[4:0]);
      PFS_RATE_DIV64: rate_tick = (c == PRE_DIV64);
      default:        rate_tick = 1'b1;
    endcase
  endfunction : rate_tick

  // ****************************************************************
  // Per-pin filters
  // ****************************************************************
  for (genvar g = 0; g < NPIN; g++) begin : g_filt
    pfs_filt_if fl ();

    assign fl.raw    = sync2_r[g];
    assign fl.enable = flte_r[g];                                           // R13
    assign fl.tick   = rate_tick(pfs_rate_t'(fltc_r[g*FLTC_W +: FLTC_W]), pre_r); // R10 R14
    assign filt_lvl[g] = fl.level;

    pfs_filter u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .fi      (fl.filt)
    );
  end

  // ****************************************************************
  // Trigger detection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev_r <= {NPIN{FILT_RST}};
    end else begin
      lvl_prev_r <= filt_lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= BITS_RST;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        case (detmd_r[i])
          PFS_DET_LOW:  irq_r[i] <= irq_input_select_r[i] && !filt_lvl[i]; // R7 R9
          PFS_DET_FALL: irq_r[i] <= irq_input_select_r[i] && lvl_prev_r[i] && !filt_lvl[i];
          PFS_DET_RISE: irq_r[i] <= irq_input_select_r[i] && !lvl_prev_r[i] && filt_lvl[i];
          PFS_DET_BOTH: irq_r[i] <= irq_input_select_r[i] && (lvl_prev_r[i] != filt_lvl[i]);
          default:      irq_r[i] <= 1'b0;
        endcase
      end
    end
  end

  assign irq_req = irq_r;

  // Only designated pins may wake from deep standby
  assign ds_wake = deep_standby && |(irq_r & DS_WAKE_MASK); // R15

endmodule : pfs_top

/* File: testbench/pfs_top_chk.sv */
// Port checker for pfs_top, bound onto every instance.
// Assumes one pclk domain and the pfs_pkg register map.
`timescale 1ns/1ps
module pfs_top_chk
  import pfs_pkg::*;
#(
  parameter logic [NPIN-1:0] DS_WAKE_MASK = 8'h0f
)(
  // APB
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [AW-1:0]    paddr,
  input wire logic             pready,
  input wire logic             pslverr,
  // Pins, peripherals, interrupts
  input wire logic [NFUNC-1:0] func_oe,
  input wire logic [NPIN-1:0]  pin_out,
  input wire logic [NPIN-1:0]  pin_oe_n,
  input wire logic [NPIN-1:0]  analog_en,
  input wire logic [NPIN-1:0]  irq_req,
  input wire logic             deep_standby,
  input wire logic             ds_wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr[1:0] == 2'h0 &&
                  (paddr <= PIN_OFF || (paddr >= IRQCR_BASE && paddr <= IRQST_OFF));

  a_ready_now: assert property (pready)
    else $error("ready low");
  a_err_mapped: assert property (psel && penable |-> pslverr == !mapped)
    else $error("wrong slave error");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_analog_quiet: assert property ((analog_en & (~pin_oe_n | pin_out)) == 8'h00)
    else $error("analog pin driven");
  a_reset_input: assert property ($rose(presetn) |->
                                  &pin_oe_n && !(|analog_en) && !(|irq_req))
    else $error("pins not inputs after reset");
  a_wake_cause: assert property (ds_wake == (deep_standby && |(irq_req & DS_WAKE_MASK)))
    else $error("wake mismatch");
  a_oe_cause: assert property (!$stable(pin_oe_n) |->
                               !$stable(func_oe) || $past(psel && penable && pwrite))
    else $error("enable changed without cause");
  a_ana_write: assert property (!$stable(analog_en) |-> $past(psel && penable && pwrite))
    else $error("analog select changed without write");

  c_irq: cover property ($rose(irq_req[0]));
  c_wake: cover property (ds_wake);
  c_err: cover property (pslverr);
endmodule : pfs_top_chk

bind pfs_top pfs_top_chk #(.DS_WAKE_MASK(DS_WAKE_MASK)) u_chk (.*);

/* File: testbench/pfs_far_model.sv */
// Peripherals and interrupt sources facing pfs_top.
// Assumes callers enter tasks just after a rising pclk edge.
`timescale 1ns/1ps
module pfs_far_model
  import pfs_pkg::*;
(
  // Clock
  input wire logic        pclk,
  // Pin and peripheral lines
  output logic [NPIN-1:0]  pin_in,
  output logic [NFUNC-1:0] func_out,
  output logic [NFUNC-1:0] func_oe
);
  initial begin
    pin_in   = 8'hff;
    func_out = 32'h0;
    func_oe  = 32'h0;
  end
  // New values each cycle so a stale route cannot match by luck
  always @(posedge pclk) begin
    func_out <= $urandom;
    func_oe  <= $urandom;
  end
  task automatic pulse(input int p, input logic v, input int w);
    pin_in[p] <= v;
    repeat (w) @(posedge pclk);
    pin_in[p] <= ~v;
  endtask : pulse
  task automatic set_pins(input logic [NPIN-1:0] v);
    pin_in <= v;
  endtask : set_pins
endmodule : pfs_far_model

/* File: testbench/pfs_top_test.sv */
// Self-checking bench for pfs_top with a shadow model of its registers.
// Assumes pfs_far_model on the far side and the pfs_pkg map.
`timescale 1ns/1ps
module pfs_top_test;
  import pfs_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic             deep_standby, ds_wake;
  logic [AW-1:0]    paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [NPIN-1:0]  pin_in, pin_out, pin_oe_n, analog_en, irq_req, mode, dir, latch, an;
  logic [NFUNC-1:0] func_out, func_oe, func_in;
  int               error_cnt, checks, lat0, lat, c0, p;
  int               irq_cnt [NPIN];
  int               code [NPIN];
  int               exp_q [$] = '{5, 1, 1, 2, 0};
  int               rate_q [$] = '{1, 8, 32, 64};

  pfs_top uut (.*);
  pfs_far_model u_far (.*);

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    for (int i = 0; i < NPIN; i++) if (irq_req[i] === 1'b1) irq_cnt[i]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic apb(input logic w, input int a, input int d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a[AW-1:0];
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end else begin
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input int a, input int x, input logic xe);
    apb(1'b0, a, 0);
    chk(q, x, "read");
    chk({31'h0, e}, {31'h0, xe}, "error flag");
  endtask : rd

  task automatic wr(input int a, input int d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic wait_irq(input int pin, output int n);
    n = 0;
    while (irq_req[pin] !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    // A missing request is a fault, not a measurement
    if (n >= 600) begin
      error_cnt++;
      complete_run();
    end else begin
      chk({31'h0, ds_wake}, 32'h1, "wake");
    end
  endtask : wait_irq

  task automatic chk_pins;
    logic [NPIN-1:0]  xo, xe;
    logic [NFUNC-1:0] xf;
    int               c;
    @(negedge pclk);
    xf = '0;
    for (int n = 0; n < NPIN; n++) begin
      c = code[n] & 'h1f;
      xo[n] = an[n] ? 1'b0 : mode[n] ? func_out[c] : latch[n];
      xe[n] = an[n] ? 1'b1 : mode[n] ? !func_oe[c] : !dir[n];
      if (mode[n] && !an[n]) xf[c] = xf[c] | pin_in[n];
    end
    chk(pin_out, xo, "pin out");
    chk(pin_oe_n, xe, "pin enable");
    chk(analog_en, an, "analog");
    chk(func_in, xf, "func in");
  endtask : chk_pins

  initial begin
    {pclk, presetn, psel, penable, pwrite, deep_standby} = 6'h0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(2));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 'h68; a += 4)
      rd(a, a == 'h20 ? 'h80 : (a == 'h30 || a == 'h68) ? 'hff : 0,
         a inside {['h34:'h3c]});
    rd('hfc, 0, 1'b1);
    wr(PFS_BASE, 'h0a);
    rd(PFS_BASE, 0, 1'b0);
    wr(WPROT_OFF, 'h40);
    rd(WPROT_OFF, 0, 1'b0);
    wr(WPROT_OFF, 0);
    wr(WPROT_OFF, 'h40);
    rd(WPROT_OFF, 'h40, 1'b0);
    // ****************
    // Random pin routing, shared functions included
    // ****************
    repeat (6) begin
      u_far.set_pins($urandom);
      wr(PMODE_OFF, 0);
      {mode, dir, latch} = $urandom;
      for (int n = 0; n < NPIN; n++) code[n] = $urandom & 'hdf;
      code[1] = code[0] & 'h5f;
      for (int n = 0; n < NPIN; n++) an[n] = code[n][7];
      mode = (mode | 8'h03) & ~an & 8'h7f;
      dir = (dir & ~an) | 8'h80;
      latch[7] = 1'b0;
      for (int n = 0; n < NPIN; n++) wr(PFS_BASE + 4 * n, code[n]);
      wr(PDIR_OFF, dir);
      wr(POUT_OFF, latch);
      wr(PMODE_OFF, mode);
      rd(PFS_BASE + 4, code[1], 1'b0);
      chk_pins();
    end
    // ****************
    // Detect modes on pin 0
    // ****************
    u_far.set_pins(8'hff);
    deep_standby <= 1'b1;
    wr(PFS_BASE, 'h43);
    foreach (exp_q[m]) begin
      if (m == 4) wr(PFS_BASE, 'h03);
      wr(IRQCR_BASE, (m & 3) << IRQ_DETECT_MODE_LSB);
      c0 = irq_cnt[0];
      fork
        u_far.pulse(0, 1'b0, 5);
        if (m != 4) wait_irq(0, lat);
      join
      repeat (10) @(posedge pclk);
      if (m == 1) lat0 = lat;
      chk(irq_cnt[0] - c0, exp_q[m], "irq count");
    end
    // ****************
    // Filter per pin, each rate
    // ****************
    foreach (rate_q[r]) begin
      p = rate_q[r];
      wr(PFS_BASE + 4 * r, 'h40);
      wr(IRQCR_BASE + 4 * r, 'h04);
      wr(FLTE_OFF, 1 << r);
      wr(FLTC_OFF, (r << (2 * r)) | ($urandom & 'hffff & ~(3 << (2 * r))));
      repeat (200) @(posedge pclk);
      c0 = irq_cnt[r];
      u_far.pulse(r, 1'b0, 2 * p);
      repeat (4 * p + 10) @(posedge pclk);
      chk(irq_cnt[r] - c0, 0, "short pulse");
      fork
        u_far.pulse(r, 1'b0, 3 * p);
        wait_irq(r, lat);
      join
      repeat (4 * p + 10) @(posedge pclk);
      chk(irq_cnt[r] - c0, 1, "long pulse");
      chk(lat > lat0, 1, "latency");
    end
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule : pfs_top_test
